// [design/clr_params.svh]
// constants of the converter link control register bank
// assumes the includer is a package or module compiled after this header
// Function
// - noise injection bit turns dither on
// - level bit picks small or large dither
// - bit two steers dither rounding error
// - marker bit rides on sample LSB
// - marker delay matches analog input latency
// - wide link field keeps converter LSB intact
// - control bit count in ILA stays zero
// - link enable bit, resets to one
// - disabled link: reset, power down, gated
// - disabled link holds multiframe counter reset
// - six bit output format, resets zero
// - multiframe length is frames minus one
// - 64B/66B uses 256 times E over F
`ifndef CLR_PARAMS_SVH
`define CLR_PARAMS_SVH

// register indices; byte address is four times the index
`define CLR_IDX_DITH        10'h09D
`define CLR_IDX_MARK        10'h160
`define CLR_IDX_EN          10'h200
`define CLR_IDX_FMT         10'h201
`define CLR_IDX_KM          10'h202

`define CLR_RST_DITH        8'h00
`define CLR_RST_MARK        8'h00
`define CLR_RST_EN          8'h01
`define CLR_RST_FMT         8'h00
`define CLR_RST_KM          8'h1F

`define CLR_BIT_DITH_EN     0
`define CLR_BIT_DITH_AMP    1
`define CLR_BIT_DITH_ERR    2
`define CLR_BIT_MARK_EN     0
`define CLR_BIT_LINK_EN     0
`define CLR_FMT_MSB         5

`define CLR_EMB_FACTOR      16'h0100
`define CLR_ILA_CS          2'h0
`define CLR_MARKER_DELAY    4

`define CLR_RESP_OKAY       2'h0
`define CLR_RESP_SLVERR     2'h2

`endif

// [design/clr_pkg.sv]
// types and decode shared by the register bank modules
// assumes clr_params.svh is on the include path
package clr_pkg;
`include "clr_params.svh"

  typedef enum logic [2:0] {
    CLR_SEL_NONE,
    CLR_SEL_DITH,
    CLR_SEL_MARK,
    CLR_SEL_EN,
    CLR_SEL_FMT,
    CLR_SEL_KM
  } clr_sel_t;

  // byte address to register; misaligned or unmapped gives none
  function automatic clr_sel_t clr_decode(input logic [11:0] addr);
    clr_sel_t s;
    s = CLR_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[11:2])
        `CLR_IDX_DITH: s = CLR_SEL_DITH;
        `CLR_IDX_MARK: s = CLR_SEL_MARK;
        `CLR_IDX_EN:   s = CLR_SEL_EN;
        `CLR_IDX_FMT:  s = CLR_SEL_FMT;
        `CLR_IDX_KM:   s = CLR_SEL_KM;
        default:       s = CLR_SEL_NONE;
      endcase
    end
    return s;
  endfunction
endpackage

// [design/clr_core_if.sv]
// internal carrier between the bus slave, register file and link control
// assumes all parties share one clock
`timescale 1ns/1ps
interface clr_core_if;
  logic                wr_en;
  clr_pkg::clr_sel_t   wr_sel;
  logic [7:0]          wr_data;
  clr_pkg::clr_sel_t   rd_sel;
  logic [7:0]          rd_data;
  logic                link_on;
  logic [7:0]          km1;
  logic [15:0]         frames_eff;

  modport slv  (output wr_en, wr_sel, wr_data, rd_sel, input rd_data);
  modport regs (input wr_en, wr_sel, wr_data, rd_sel, output rd_data,
                output link_on, km1, input frames_eff);
  modport lnk  (input link_on, km1, output frames_eff);
endinterface

// [design/clr_axi_slave.sv]
// AXI4-Lite slave: one write and one read in flight, byte lane 0 only
// assumes a master that holds valid and payload until taken
`timescale 1ns/1ps
`include "clr_params.svh"
module clr_axi_slave (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  clr_core_if.slv          bus
);
  logic        aw_held_reg;
  logic [11:0] awaddr_reg;
  logic        w_held_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        do_wr;
  clr_pkg::clr_sel_t wsel;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wsel    = clr_pkg::clr_decode(awaddr_reg);
  // only lane 0 carries register bits; other lanes are dropped
  assign bus.wr_en   = do_wr && wstrb0_reg && (wsel != clr_pkg::CLR_SEL_NONE);
  assign bus.wr_sel  = wsel;
  assign bus.wr_data = wdata_reg;
  assign bus.rd_sel  = clr_pkg::clr_decode(s_axi_araddr);

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CLR_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == clr_pkg::CLR_SEL_NONE) ? `CLR_RESP_SLVERR : `CLR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CLR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, bus.rd_data};
      s_axi_rresp  <= (bus.rd_sel == clr_pkg::CLR_SEL_NONE) ? `CLR_RESP_SLVERR : `CLR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [design/clr_link_ctrl.sv]
// effective frames per multiframe and the multiframe clock counter
// assumes frame_tick and sysref_pulse are one-cycle pulses on clk
`timescale 1ns/1ps
`include "clr_params.svh"
module clr_link_ctrl (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        frame_tick,
  input  wire logic        sysref_pulse,
  input  wire logic        mode_uses_64b66b,
  input  wire logic [7:0]  mode_e,
  input  wire logic [7:0]  mode_f,
  output      logic [15:0] multiframe_clock_counter,
  output      logic        multiframe_start,
  clr_core_if.lnk          lnk
);
  logic [15:0] frames_reg;
  logic [15:0] frames_next;
  logic        wrap;

  // F of zero is illegal; fall back to one frame rather than divide by zero
  function automatic logic [15:0] clr_emb_frames(input logic [7:0] e, input logic [7:0] f);
    logic [23:0] prod;
    prod = {8'h00, `CLR_EMB_FACTOR} * {16'h0000, e};
    if (f == 8'h00)
      return 16'h0001;
    return 16'(prod / {16'h0000, f});
  endfunction

  always_comb begin
    if (mode_uses_64b66b)
      frames_next = clr_emb_frames(mode_e, mode_f);
    else
      frames_next = {8'h00, lnk.km1} + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst)
      frames_reg <= {8'h00, `CLR_RST_KM} + 16'h0001;
    else
      frames_reg <= frames_next;
  end

  assign lnk.frames_eff = frames_reg;
  assign wrap = (multiframe_clock_counter >= frames_reg - 16'h0001);

  always_ff @(posedge clk) begin
    if (srst || !lnk.link_on)
      multiframe_clock_counter <= 16'h0000;
    else if (sysref_pulse)
      multiframe_clock_counter <= 16'h0000;
    else if (frame_tick)
      multiframe_clock_counter <= wrap ? 16'h0000 : multiframe_clock_counter + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst)
      multiframe_start <= 1'b0;
    else
      multiframe_start <= lnk.link_on && (sysref_pulse || (frame_tick && wrap));
  end

  mfc_hold_a: assert property (@(posedge clk) disable iff (srst)
    !lnk.link_on |=> multiframe_clock_counter == 16'h0000)
    else $error("multiframe counter not held while link off");

  k_plain_a: assert property (@(posedge clk) disable iff (srst)
    !mode_uses_64b66b |=> frames_reg == {8'h00, $past(lnk.km1)} + 16'h0001)
    else $error("frames per multiframe not length plus one");

  k_emb_a: assert property (@(posedge clk) disable iff (srst)
    mode_uses_64b66b && mode_e == 8'h01 && mode_f == 8'h08 |=> frames_reg == 16'h0020)
    else $error("embedded header frame count wrong");
endmodule

// [design/clr_top.sv]
// converter link control register bank with AXI4-Lite access
// assumes samples arrive already aligned to analog latency at conv_sample
`timescale 1ns/1ps
`include "clr_params.svh"
module clr_top #(
  parameter int CONV_W       = 12,
  parameter int LINK_W       = 16,
  parameter int MARKER_DELAY = `CLR_MARKER_DELAY
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic              noise_injection_on,
  output      logic              noise_injection_level,
  output      logic              rounding_error_target,
  output      logic              marker_bit_insert_on,
  output      logic              link_subsystem_on,
  output      logic [5:0]        link_output_format,
  output      logic              link_reset_hold,
  output      logic              serializer_power_down,
  output      logic              serializer_clk_en,
  output      logic [1:0]        ila_control_bits,
  input  wire logic              frame_tick,
  input  wire logic              sysref_pulse,
  input  wire logic              mode_uses_64b66b,
  input  wire logic [7:0]        mode_e,
  input  wire logic [7:0]        mode_f,
  output      logic [15:0]       frames_per_multiframe,
  output      logic [15:0]       multiframe_clock_counter,
  output      logic              multiframe_start,
  input  wire logic [CONV_W-1:0] conv_sample,
  input  wire logic              conv_sample_valid,
  input  wire logic              timestamp_in,
  output      logic [LINK_W-1:0] link_sample,
  output      logic              link_sample_valid
);
  clr_core_if core ();

  logic [7:0]  dith_reg;
  logic [7:0]  mark_reg;
  logic [7:0]  en_reg;
  logic [7:0]  fmt_reg;
  logic [7:0]  km_reg;
  logic [MARKER_DELAY-1:0] ts_line_reg;
  logic [LINK_W-1:0]       sample_next;

  clr_axi_slave u_axi (
    .clk           (clk),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .bus           (core.slv)
  );

  clr_link_ctrl u_link (
    .clk                      (clk),
    .srst                     (srst),
    .frame_tick               (frame_tick),
    .sysref_pulse             (sysref_pulse),
    .mode_uses_64b66b         (mode_uses_64b66b),
    .mode_e                   (mode_e),
    .mode_f                   (mode_f),
    .multiframe_clock_counter (multiframe_clock_counter),
    .multiframe_start         (multiframe_start),
    .lnk                      (core.lnk)
  );

  // stored values with reset defaults; reserved bits kept as written
  always_ff @(posedge clk) begin
    if (srst)
      dith_reg <= `CLR_RST_DITH;
    else if (core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_DITH)
      dith_reg <= core.wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      mark_reg <= `CLR_RST_MARK;
    else if (core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_MARK)
      mark_reg <= core.wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      en_reg <= `CLR_RST_EN;
    else if (core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_EN)
      en_reg <= core.wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      fmt_reg <= `CLR_RST_FMT;
    else if (core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_FMT)
      fmt_reg <= core.wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      km_reg <= `CLR_RST_KM;
    else if (core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_KM)
      km_reg <= core.wr_data;
  end

  always_comb begin
    case (core.rd_sel)
      clr_pkg::CLR_SEL_DITH: core.rd_data = dith_reg;
      clr_pkg::CLR_SEL_MARK: core.rd_data = mark_reg;
      clr_pkg::CLR_SEL_EN:   core.rd_data = en_reg;
      clr_pkg::CLR_SEL_FMT:  core.rd_data = fmt_reg;
      clr_pkg::CLR_SEL_KM:   core.rd_data = km_reg;
      default:               core.rd_data = 8'h00;
    endcase
  end

  assign noise_injection_on    = dith_reg[`CLR_BIT_DITH_EN];
  assign noise_injection_level = dith_reg[`CLR_BIT_DITH_AMP];
  assign rounding_error_target = dith_reg[`CLR_BIT_DITH_ERR];
  assign marker_bit_insert_on  = mark_reg[`CLR_BIT_MARK_EN];
  assign link_subsystem_on     = en_reg[`CLR_BIT_LINK_EN];
  assign link_output_format    = fmt_reg[`CLR_FMT_MSB:0];
  // reset, power down and clock gate
  assign link_reset_hold       = !link_subsystem_on;
  assign serializer_power_down = !link_subsystem_on;
  assign serializer_clk_en     = link_subsystem_on;
  assign ila_control_bits      = `CLR_ILA_CS;

  assign core.link_on          = link_subsystem_on;
  assign core.km1              = km_reg;
  assign frames_per_multiframe = core.frames_eff;

  // timestamp delayed to match the sample path latency
  always_ff @(posedge clk) begin
    if (srst)
      ts_line_reg <= '0;
    else
      ts_line_reg <= {ts_line_reg[MARKER_DELAY-2:0], timestamp_in};
  end

  // converter bits sit at the top, padding below them
  always_comb begin
    sample_next = '0;
    sample_next[LINK_W-1 -: CONV_W] = conv_sample;
    if (marker_bit_insert_on)
      sample_next[0] = ts_line_reg[MARKER_DELAY-1];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link_sample       <= '0;
      link_sample_valid <= 1'b0;
    end else begin
      link_sample_valid <= conv_sample_valid;
      if (conv_sample_valid)
        link_sample <= sample_next;
    end
  end

  sequence wr_dith_s;
    core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_DITH;
  endsequence

  sequence wr_en_s;
    core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_EN;
  endsequence

  dith_enable_a: assert property (@(posedge clk) disable iff (srst)
    wr_dith_s |=> noise_injection_on == $past(core.wr_data[`CLR_BIT_DITH_EN]))
    else $error("dither enable did not follow write");

  dith_level_a: assert property (@(posedge clk) disable iff (srst)
    wr_dith_s ##1 !core.wr_en[*2] |->
      noise_injection_level == $past(core.wr_data[`CLR_BIT_DITH_AMP], 2))
    else $error("dither level lost after write");

  round_target_a: assert property (@(posedge clk) disable iff (srst)
    wr_dith_s |=> rounding_error_target == $past(core.wr_data[`CLR_BIT_DITH_ERR]))
    else $error("rounding target did not follow write");

  marker_lsb_a: assert property (@(posedge clk) disable iff (srst)
    conv_sample_valid && marker_bit_insert_on |=>
      link_sample[0] == $past(timestamp_in, MARKER_DELAY + 1))
    else $error("marker bit not on sample LSB with expected delay");

  conv_keep_a: assert property (@(posedge clk) disable iff (srst)
    conv_sample_valid |=> link_sample[LINK_W-1 -: CONV_W] == $past(conv_sample))
    else $error("converter bits overwritten in link field");

  ila_zero_a: assert property (@(posedge clk) disable iff (srst)
    ila_control_bits == 2'h0)
    else $error("control bit count advertised");

  link_gate_a: assert property (@(posedge clk) disable iff (srst)
    wr_en_s and !core.wr_data[`CLR_BIT_LINK_EN] |=>
      link_reset_hold && serializer_power_down && !serializer_clk_en)
    else $error("disabled link not held in reset");

  // first edge after release only; before that the registers may still be unknown
  reset_vals_a: assert property (@(posedge clk)
    !srst && $past(srst) |-> en_reg == `CLR_RST_EN && fmt_reg == `CLR_RST_FMT
      && km_reg == `CLR_RST_KM && dith_reg == `CLR_RST_DITH && mark_reg == `CLR_RST_MARK)
    else $error("register defaults wrong after reset");

  en_write_a: assert property (@(posedge clk) disable iff (srst)
    wr_en_s |=> link_subsystem_on == $past(core.wr_data[`CLR_BIT_LINK_EN]))
    else $error("link enable did not follow write");

  mark_write_a: assert property (@(posedge clk) disable iff (srst)
    core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_MARK |=>
      marker_bit_insert_on == $past(core.wr_data[`CLR_BIT_MARK_EN]))
    else $error("marker enable did not follow write");

  // padding bit stays clear when no marker is inserted
  marker_off_a: assert property (@(posedge clk) disable iff (srst)
    conv_sample_valid && !marker_bit_insert_on |=> !link_sample[0])
    else $error("marker bit set while insertion off");

  km_write_a: assert property (@(posedge clk) disable iff (srst)
    core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_KM |=> km_reg == $past(core.wr_data))
    else $error("multiframe length did not follow write");

  reg_hold_a: assert property (@(posedge clk) disable iff (srst)
    !core.wr_en |=> $stable(dith_reg) && $stable(mark_reg) && $stable(en_reg)
      && $stable(fmt_reg) && $stable(km_reg))
    else $error("register changed without a write");

  fmt_write_a: assert property (@(posedge clk) disable iff (srst)
    core.wr_en && core.wr_sel == clr_pkg::CLR_SEL_FMT |=>
      link_output_format == $past(core.wr_data[5:0]))
    else $error("output format did not follow write");

  read_back_a: assert property (@(posedge clk) disable iff (srst)
    s_axi_arvalid && s_axi_arready && core.rd_sel == clr_pkg::CLR_SEL_KM |=>
      s_axi_rvalid && s_axi_rdata[7:0] == $past(km_reg))
    else $error("read did not return stored value");
endmodule

// [bench/clr_bench.sv]
// self-checking bench for the converter link control register bank
// assumes clr_top with AXI4-Lite access and a 25 MHz clock
`timescale 1ns/1ps
module clr_bench;
  localparam int MD = 4;
  logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr, smp;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, ila_bits;
  logic        dith_on, dith_lvl, dith_err, mark_on, link_on, rst_hold, ser_pd, ser_ce;
  logic        tick, sysref, m64, mf_start, smp_valid, ts_in, lnk_valid, mf_seen;
  logic [5:0]  fmt;
  logic [7:0]  mode_e, mode_f;
  logic [15:0] frames, mf_cnt, lnk_smp;
  int          bad_count, compares;

  clr_top #(.CONV_W(12), .LINK_W(16), .MARKER_DELAY(MD)) dut (
    .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .noise_injection_on(dith_on),
    .noise_injection_level(dith_lvl), .rounding_error_target(dith_err),
    .marker_bit_insert_on(mark_on), .link_subsystem_on(link_on),
    .link_output_format(fmt), .link_reset_hold(rst_hold),
    .serializer_power_down(ser_pd), .serializer_clk_en(ser_ce),
    .ila_control_bits(ila_bits), .frame_tick(tick), .sysref_pulse(sysref),
    .mode_uses_64b66b(m64), .mode_e(mode_e), .mode_f(mode_f),
    .frames_per_multiframe(frames), .multiframe_clock_counter(mf_cnt),
    .multiframe_start(mf_start), .conv_sample(smp), .conv_sample_valid(smp_valid),
    .timestamp_in(ts_in), .link_sample(lnk_smp), .link_sample_valid(lnk_valid)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mf_start === 1'b1) mf_seen <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic       aw_t, w_t, b_t;
    logic [1:0] resp;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      #1;
      aw_t = awvalid & (awready === 1'b1);
      w_t = wvalid & (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      resp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er}, "write response");
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic        ar_t, r_t;
    logic [31:0] d;
    logic [1:0]  resp;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      #1;
      ar_t = arvalid & (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, {24'h0, ed}, "read data");
    chk({30'h0, resp}, {30'h0, er}, "read response");
  endtask

  // one-cycle pulse, then time for the counter to settle
  task automatic pulse(input logic t, input logic s);
    @(posedge clk);
    tick <= t;
    sysref <= s;
    @(posedge clk);
    tick <= 1'b0;
    sysref <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_reset;
    axi_rd(12'h274, 8'h00, 2'h0);
    axi_rd(12'h580, 8'h00, 2'h0);
    axi_rd(12'h800, 8'h01, 2'h0);
    axi_rd(12'h804, 8'h00, 2'h0);
    axi_rd(12'h808, 8'h1F, 2'h0);
    chk({31'h0, link_on}, 32'h1, "link on after reset");
    chk({16'h0, frames}, 32'h20, "frames after reset");
    chk({30'h0, ila_bits}, 32'h0, "ila control bits");
  endtask

  task automatic test_dither(input logic [7:0] v);
    axi_wr(12'h274, v, 4'hF, 2'h0);
    #1;
    chk({31'h0, dith_on}, {31'h0, v[0]}, "noise on");
    chk({31'h0, dith_lvl}, {31'h0, v[1]}, "noise level");
    chk({31'h0, dith_err}, {31'h0, v[2]}, "rounding target");
    axi_rd(12'h274, v, 2'h0);
  endtask

  task automatic test_link_cfg;
    axi_wr(12'h800, 8'h00, 4'hF, 2'h0);
    #1;
    chk({29'h0, rst_hold, ser_pd, ser_ce}, 32'h6, "disabled link gating");
    axi_wr(12'h804, 8'h2A, 4'hF, 2'h0);
    axi_rd(12'h804, 8'h2A, 2'h0);
    chk({26'h0, fmt}, 32'h2A, "output format");
    axi_wr(12'h804, 8'h11, 4'h0, 2'h0);
    axi_rd(12'h804, 8'h2A, 2'h0);
    axi_wr(12'h808, 8'h0F, 4'hF, 2'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({16'h0, frames}, 32'h10, "frames from length");
    @(posedge clk);
    m64 <= 1'b1;
    mode_e <= 8'h03;
    mode_f <= 8'h04;
    repeat (3) @(posedge clk);
    #1;
    chk({16'h0, frames}, 32'hC0, "frames in 64b66b");
    @(posedge clk);
    mode_e <= 8'h01;
    mode_f <= 8'h08;
    repeat (3) @(posedge clk);
    #1;
    chk({16'h0, frames}, 32'h20, "frames in 64b66b with E 1 F 8");
    @(posedge clk);
    m64 <= 1'b0;
  endtask

  task automatic test_counter;
    axi_wr(12'h808, 8'h03, 4'hF, 2'h0);
    axi_wr(12'h800, 8'h01, 4'hF, 2'h0);
    #1;
    chk({29'h0, rst_hold, ser_pd, ser_ce}, 32'h1, "enabled link gating");
    mf_seen = 1'b0;
    pulse(1'b0, 1'b1);
    chk({31'h0, mf_seen}, 32'h1, "multiframe start on sysref");
    for (int k = 1; k <= 5; k++) begin
      pulse(1'b1, 1'b0);
      chk({16'h0, mf_cnt}, k % 4, "counter after tick");
    end
    axi_wr(12'h800, 8'h00, 4'hF, 2'h0);
    mf_seen = 1'b0;
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b0);
    chk({16'h0, mf_cnt}, 32'h0, "counter held while off");
    chk({31'h0, mf_seen}, 32'h0, "no start while off");
  endtask

  task automatic test_marker(input logic on);
    logic [15:0] exp;
    axi_wr(12'h580, {7'h0, on}, 4'hF, 2'h0);
    #1;
    chk({31'h0, mark_on}, {31'h0, on}, "marker enable");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      smp <= 12'hA50 + 12'(i);
      smp_valid <= 1'b1;
      ts_in <= (i == 2);
      #1;
      if (i > 0) begin
        exp = {12'hA50 + 12'(i - 1), 4'h0};
        exp[0] = on & (i - 1 - MD == 2);
        chk({16'h0, lnk_smp}, {16'h0, exp}, "link sample");
        chk({31'h0, lnk_valid}, 32'h1, "link sample valid");
      end
    end
    @(posedge clk);
    smp_valid <= 1'b0;
  endtask

  task automatic test_errors;
    axi_rd(12'h00C, 8'h00, 2'h2);
    axi_wr(12'h00C, 8'h5A, 4'hF, 2'h2);
    axi_wr(12'h801, 8'h01, 4'hF, 2'h2);
    axi_rd(12'h800, 8'h00, 2'h0);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #800000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    bad_count = 0;
    compares = 0;
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    {tick, sysref, m64, smp_valid, ts_in} = 5'h00;
    mode_e = 8'h01;
    mode_f = 8'h01;
    smp = 12'h000;
    mf_seen = 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    test_reset();
    test_dither(8'h05);
    test_dither(8'h02);
    test_link_cfg();
    test_counter();
    test_marker(1'b1);
    test_marker(1'b0);
    test_errors();
    complete_run();
  end
endmodule
